// ===== gpio_port_b_pkg.sv
// Constants shared by the general-purpose port with change detection.
`default_nettype none
package gpio_port_b_pkg;
  localparam int          DATA_W      = 32;
  localparam int          ADDR_W      = 12;
  localparam int          PORT_W      = 8;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0]  IDX_PORT    = 8'h06;
  localparam logic [7:0]  IDX_DIR     = 8'h86;
  localparam logic [7:0]  IDX_OPTION  = 8'h81;
  localparam logic [7:0]  IDX_INTCTL  = 8'h0B;
  localparam logic [7:0]  IDX_BITSET  = 8'h20;
  localparam logic [7:0]  IDX_BITCLR  = 8'h21;
  localparam logic [7:0]  IDX_STATUS  = 8'h40;
  localparam logic [7:0]  IDX_MASK    = 8'h41;
  localparam logic [ADDR_W-1:0] ADDR_PORT   = {2'h0, IDX_PORT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_DIR    = {2'h0, IDX_DIR, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_OPTION = {2'h0, IDX_OPTION, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_INTCTL = {2'h0, IDX_INTCTL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_BITSET = {2'h0, IDX_BITSET, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_BITCLR = {2'h0, IDX_BITCLR, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_MASK   = {2'h0, IDX_MASK, 2'h0};
  // Field positions.
  localparam int          OPT_PULLUP_DIS_N = 7;
  localparam int          INTCTL_FLAG      = 0;
  localparam int          INTCTL_ENABLE    = 3;
  localparam int          STAT_CHANGE      = 0;
  localparam int          STAT_WAKE        = 1;
  localparam int          STAT_W           = 2;
  localparam int          WATCH_LO         = 4;
  localparam int          PROG_PIN         = 4;
  // Reset values.
  localparam logic [7:0]  RST_OPTION  = 8'hFF;
  localparam logic [7:0]  RST_DIR     = 8'hFF;
  localparam logic [7:0]  RST_LATCH   = 8'h00;
  localparam logic [7:0]  RST_INTCTL  = 8'h00;
  localparam logic [STAT_W-1:0] RST_STATUS = 2'h0;
  localparam logic [STAT_W-1:0] RST_MASK   = 2'h0;
endpackage : gpio_port_b_pkg
`default_nettype wire

// ===== gpio_port_b.sv
// Eight-pin bidirectional port with pull-ups, change detection and APB registers.
//
// Operation
// RULE1 - Direction bit one puts the pin driver in high impedance.
// RULE2 - Direction bit zero drives the pin from its output latch.
// RULE3 - An enabled alternate function controls the pin regardless of direction.
// RULE4 - Peripheral output enable acts only while that peripheral is selected.
// RULE5 - Port reads return pin levels; port writes load only the latches.
// RULE6 - Bit writes read pins, modify, then store the whole latch.
// RULE7 - Clearing option bit seven enables all eight weak pull-ups.
// RULE8 - A pin configured as output has its pull-up switched off.
// RULE9 - Pull-ups are disabled after power-on reset.
// RULE10 - Only upper four input pins take part in change detection.
// RULE11 - Watched pins compare against a reference captured on each port read.
// RULE12 - Per-pin mismatches OR together and set the pin change flag.
// RULE13 - A pin change can wake the device from sleep.
// RULE14 - A lasting mismatch keeps setting the flag; software reads port, then clears.
// RULE15 - A change coinciding with a port read may fail to set the flag.
// RULE16 - Low-voltage programming disables change detection and pull-up on its pin.
// RULE17 - Software should avoid polling the port while using change detection.
// RULE18 - Writes commit at cycle end; reads sample pins at cycle start.
// RULE19 - The flag requests an interrupt only while its enable bit is set.
`default_nettype none
module gpio_port_b
(
  // Clock and reset.
  input  wire logic                           core_clk,
  input  wire logic                           arst_n,
  // APB slave.
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [gpio_port_b_pkg::ADDR_W-1:0] paddr,
  input  wire logic [gpio_port_b_pkg::DATA_W-1:0] pwdata,
  output logic      [gpio_port_b_pkg::DATA_W-1:0] prdata,
  output logic                                pready,
  output logic                                pslverr,
  // Pins.
  input  wire logic [gpio_port_b_pkg::PORT_W-1:0] pin_in,
  output logic      [gpio_port_b_pkg::PORT_W-1:0] pin_out,
  output logic      [gpio_port_b_pkg::PORT_W-1:0] pin_oe,
  output logic      [gpio_port_b_pkg::PORT_W-1:0] pullup_en,
  // Alternate peripheral functions.
  input  wire logic [gpio_port_b_pkg::PORT_W-1:0] periph_sel,
  input  wire logic [gpio_port_b_pkg::PORT_W-1:0] periph_oe,
  input  wire logic [gpio_port_b_pkg::PORT_W-1:0] periph_out,
  // Device mode.
  input  wire logic                           low_voltage_prog_enable,
  input  wire logic                           sleep_active,
  // Interrupts and wake-up.
  output logic                                cpu_int_req,
  output logic                                wake_req,
  output logic                                irq
);
  import gpio_port_b_pkg::*;

  // ************************************************************
  // Pin input synchroniser
  // ************************************************************
  logic [PORT_W-1:0] sync1;
  logic [PORT_W-1:0] sync2;
  logic [PORT_W-1:0] sync3;
  logic [PORT_W-1:0] pin_level;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end
    else
    begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A pin level is accepted only once two stages agree.
  generate
    for (genvar i = 0; i < PORT_W; i++)
    begin : g_level
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
          pin_level[i] <= 1'b0;
        else if (sync2[i] == sync3[i])
          pin_level[i] <= sync3[i];
      end
    end
  endgenerate

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic setup_ph;
  logic access_ph;
  logic wr_take;
  logic rd_setup;
  logic addr_hit;
  logic wr_port;
  logic wr_bitset;
  logic wr_bitclr;
  logic wr_dir;
  logic wr_option;
  logic wr_intctl;
  logic wr_mask;
  logic rd_port;
  logic rd_status;

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_take   = access_ph && pwrite;
  assign rd_setup  = setup_ph && !pwrite;
  assign addr_hit  = (paddr == ADDR_PORT) || (paddr == ADDR_DIR)
                  || (paddr == ADDR_OPTION) || (paddr == ADDR_INTCTL)
                  || (paddr == ADDR_BITSET) || (paddr == ADDR_BITCLR)
                  || (paddr == ADDR_STATUS) || (paddr == ADDR_MASK);
  assign wr_port   = wr_take && (paddr == ADDR_PORT);
  assign wr_bitset = wr_take && (paddr == ADDR_BITSET);
  assign wr_bitclr = wr_take && (paddr == ADDR_BITCLR);
  assign wr_dir    = wr_take && (paddr == ADDR_DIR);
  assign wr_option = wr_take && (paddr == ADDR_OPTION);
  assign wr_intctl = wr_take && (paddr == ADDR_INTCTL);
  assign wr_mask   = wr_take && (paddr == ADDR_MASK);
  assign rd_port   = rd_setup && (paddr == ADDR_PORT);
  assign rd_status = rd_setup && (paddr == ADDR_STATUS);

  // The slave never inserts wait states.
  assign pready  = 1'b1;
  assign pslverr = access_ph && !addr_hit;

  // ************************************************************
  // Port registers
  // ************************************************************
  logic [PORT_W-1:0] out_latch;
  logic [PORT_W-1:0] port_direction;
  logic [PORT_W-1:0] option_config;
  logic              pullup_disable_n;

  assign pullup_disable_n = option_config[OPT_PULLUP_DIS_N];

  // Latch writes take effect at the access edge, the end of the cycle.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      out_latch <= RST_LATCH;
    else if (wr_port)
      out_latch <= pwdata[PORT_W-1:0]; // RULE5 RULE18
    else if (wr_bitset)
      out_latch <= pin_level | pwdata[PORT_W-1:0]; // RULE6
    else if (wr_bitclr)
      out_latch <= pin_level & ~pwdata[PORT_W-1:0]; // RULE6
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      port_direction <= RST_DIR;
    else if (wr_dir)
      port_direction <= pwdata[PORT_W-1:0];
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      option_config <= RST_OPTION; // RULE9
    else if (wr_option)
      option_config <= pwdata[PORT_W-1:0];
  end

  // ************************************************************
  // Pin drivers and pull-ups
  // ************************************************************
  logic [PORT_W-1:0] prog_mask;

  assign prog_mask = low_voltage_prog_enable ? (PORT_W'(1) << PROG_PIN) : '0;

  generate
    for (genvar i = 0; i < PORT_W; i++)
    begin : g_pin
      always_comb
      begin
        if (periph_sel[i])
        begin
          pin_out[i] = periph_out[i]; // RULE3
          pin_oe[i]  = periph_oe[i]; // RULE4
        end
        else
        begin
          pin_out[i] = out_latch[i]; // RULE2
          pin_oe[i]  = !port_direction[i]; // RULE1 RULE2
        end
      end
      // Pull-up is on only for an input pin while the shared bit is clear.
      assign pullup_en[i] = !pullup_disable_n && port_direction[i]
                         && !periph_sel[i] && !prog_mask[i]; // RULE7 RULE8 RULE16
    end
  endgenerate

  // ************************************************************
  // Change detection
  // ************************************************************
  logic [PORT_W-1:0] change_ref;
  logic [3:0]        watch_en;
  logic [3:0]        pin_mismatch;
  logic              mismatch;

  // Any port read or write recaptures the reference and ends a mismatch.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      change_ref <= '0;
    else if (rd_port || wr_port || wr_bitset || wr_bitclr)
      change_ref <= pin_level; // RULE11 RULE14 RULE18
  end

  // A change landing on the capture edge is not absorbed; the reference takes the old level.
  assign watch_en     = port_direction[PORT_W-1:WATCH_LO]
                      & ~prog_mask[PORT_W-1:WATCH_LO]; // RULE10 RULE15 RULE16
  assign pin_mismatch = (pin_level[PORT_W-1:WATCH_LO]
                      ^ change_ref[PORT_W-1:WATCH_LO]) & watch_en; // RULE11
  assign mismatch     = |pin_mismatch; // RULE12

  // ************************************************************
  // Interrupt control
  // ************************************************************
  logic pin_change_flag;
  logic change_int_enable;
  logic flag_clear;

  // Writing zero to the flag clears it, but a live mismatch wins.
  assign flag_clear = wr_intctl && !pwdata[INTCTL_FLAG];

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      pin_change_flag <= RST_INTCTL[INTCTL_FLAG];
    else
      pin_change_flag <= mismatch || (pin_change_flag && !flag_clear); // RULE12 RULE14
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      change_int_enable <= RST_INTCTL[INTCTL_ENABLE];
    else if (wr_intctl)
      change_int_enable <= pwdata[INTCTL_ENABLE];
  end

  assign cpu_int_req = pin_change_flag && change_int_enable; // RULE19
  assign wake_req    = sleep_active && pin_change_flag; // RULE13

  // ************************************************************
  // Event status and mask
  // ************************************************************
  logic [STAT_W-1:0] irq_status;
  logic [STAT_W-1:0] irq_mask;
  logic [STAT_W-1:0] status_event;
  logic [STAT_W-1:0] status_taken;
  logic              status_rd_pending;

  assign status_event[STAT_CHANGE] = mismatch;
  assign status_event[STAT_WAKE]   = wake_req;

  // Only bits already returned to software are cleared; new events win.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      status_rd_pending <= 1'b0;
    else
      status_rd_pending <= rd_status;
  end

  assign status_taken = (status_rd_pending && access_ph)
                      ? prdata[STAT_W-1:0] : '0;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_status <= RST_STATUS;
    else
      irq_status <= (irq_status & ~status_taken) | status_event;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_mask <= RST_MASK;
    else if (wr_mask)
      irq_mask <= pwdata[STAT_W-1:0];
  end

  assign irq = |(irq_status & irq_mask);

  // ************************************************************
  // Read data
  // ************************************************************
  logic [DATA_W-1:0] next_prdata;

  always_comb
  begin
    next_prdata = '0;
    unique case (paddr)
      ADDR_PORT:   next_prdata[PORT_W-1:0] = pin_level; // RULE5 RULE18
      ADDR_DIR:    next_prdata[PORT_W-1:0] = port_direction;
      ADDR_OPTION: next_prdata[PORT_W-1:0] = option_config;
      ADDR_INTCTL:
      begin
        next_prdata[INTCTL_FLAG]   = pin_change_flag;
        next_prdata[INTCTL_ENABLE] = change_int_enable;
      end
      ADDR_BITSET: next_prdata[PORT_W-1:0] = out_latch;
      ADDR_BITCLR: next_prdata[PORT_W-1:0] = out_latch;
      ADDR_STATUS: next_prdata[STAT_W-1:0] = irq_status;
      ADDR_MASK:   next_prdata[STAT_W-1:0] = irq_mask;
      default:     next_prdata = '0;
    endcase
  end

  // Read data is sampled in the setup cycle, the start of the access.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      prdata <= '0;
    else if (rd_setup)
      prdata <= next_prdata;
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence seq_port_read;
    rd_port;
  endsequence
  sequence seq_bitset_taken;
    setup_ph && pwrite && (paddr == ADDR_BITSET) ##1 wr_bitset;
  endsequence
  a_input_hiz: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE1
    ((pin_oe & port_direction & ~periph_sel) == '0))
    else $error("input pin is being driven");
  a_output_drive: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE2
    wr_port |=> (((pin_out ^ $past(pwdata[PORT_W-1:0])) & ~port_direction & ~periph_sel) == '0))
    else $error("output pin does not show written latch");
  a_periph_override: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE3
    ((periph_sel & (pin_oe ^ periph_oe)) == '0)
      && ((periph_sel & (pin_out ^ periph_out)) == '0))
    else $error("selected peripheral lost control of pin");
  a_periph_oe_gate: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE4
    ((~periph_sel & (pin_oe ^ ~port_direction)) == '0))
    else $error("unselected pin ignores direction");
  a_read_pins: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE5
    seq_port_read |=> (prdata[PORT_W-1:0] == $past(pin_level))
      && (out_latch == $past(out_latch)))
    else $error("port read did not return pin levels");
  a_rmw_latch: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE6
    seq_bitset_taken |=> out_latch == ($past(pin_level) | $past(pwdata[PORT_W-1:0])))
    else $error("bit set did not merge pin levels");
  a_pullup_gate: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE7
    (pullup_disable_n |-> (pullup_en == '0))
      and (!pullup_disable_n && (periph_sel == '0) && !low_voltage_prog_enable
        |-> (pullup_en == port_direction)))
    else $error("pull-up enable wrong for option bit");
  a_pullup_output: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE8
    ((pullup_en & ~port_direction) == '0))
    else $error("pull-up on an output pin");
  a_reset_pullup: assert property (@(posedge core_clk) // RULE9
    $rose(arst_n) |-> (pullup_en == '0))
    else $error("pull-ups enabled after reset");
  a_watch_upper: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE10
    mismatch |-> ((port_direction[PORT_W-1:WATCH_LO]
      & (pin_level[PORT_W-1:WATCH_LO] ^ change_ref[PORT_W-1:WATCH_LO])) != '0))
    else $error("output pin caused a mismatch");
  a_ref_capture: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE11
    seq_port_read |=> (change_ref == $past(pin_level)))
    else $error("reference not captured on read");
  a_flag_set: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE12
    mismatch |=> pin_change_flag)
    else $error("mismatch did not set flag");
  a_flag_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE14
    mismatch && flag_clear |=> pin_change_flag ##1 (pin_change_flag || !$past(mismatch)))
    else $error("flag cleared during mismatch");
  a_wake_sleep: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE13
    sleep_active && mismatch ##1 sleep_active |-> wake_req)
    else $error("pin change did not wake");
  a_prog_excl: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE16
    low_voltage_prog_enable |-> !pullup_en[PROG_PIN] && !pin_mismatch[PROG_PIN-WATCH_LO])
    else $error("programming pin not excluded");
  a_irq_enable: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE19
    $rose(pin_change_flag) |-> (cpu_int_req == change_int_enable))
    else $error("interrupt request ignores enable");

endmodule : gpio_port_b
`default_nettype wire

// ===== gpio_pin_model.sv
// Pin-side model: external drivers, weak pull-ups and floating lines.
`default_nettype none
module gpio_pin_model
(
  // Clock.
  input  wire logic       core_clk,
  // Device pin side.
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_en,
  // External drivers.
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  // Resolved levels.
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] float_q = 8'h00;

  // An undriven line without pull-up toggles so it never reads as a stable value.
  always @(posedge core_clk)
  begin
    float_q <= ~float_q;
  end

  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & pullup_en)
                | (~pin_oe & ~ext_en & ~pullup_en & float_q);
endmodule : gpio_pin_model
`default_nettype wire

// ===== gpio_port_b_test.sv
// Self-checking testbench for the general-purpose port with change detection.
`default_nettype none
module gpio_port_b_test;
  timeunit 1ns;
  timeprecision 1ps;
  import gpio_port_b_pkg::*;
  logic              core_clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              slverr;
  logic [7:0]        pin_in, pin_out, pin_oe, pullup_en;
  logic [7:0]        periph_sel = 8'h00;
  logic [7:0]        periph_oe = 8'h00;
  logic [7:0]        periph_out = 8'h00;
  logic [7:0]        ext_val = 8'h00;
  logic [7:0]        ext_en = 8'hFF;
  logic              low_voltage_prog_enable = 1'b0;
  logic              sleep_active = 1'b0;
  logic              cpu_int_req, wake_req, irq;
  int                err_total = 0;
  int                n_tests = 0;

  always #4 core_clk = ~core_clk;

  gpio_port_b gpio_port_b_inst (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_en(pullup_en), .periph_sel(periph_sel),
    .periph_oe(periph_oe), .periph_out(periph_out),
    .low_voltage_prog_enable(low_voltage_prog_enable),
    .sleep_active(sleep_active), .cpu_int_req(cpu_int_req), .wake_req(wake_req),
    .irq(irq));

  gpio_pin_model gpio_pin_model_inst (.core_clk(core_clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_en(pullup_en), .ext_val(ext_val), .ext_en(ext_en),
    .pin_in(pin_in));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer: setup, then access held until pready is sampled high.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     output logic [DATA_W-1:0] q);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
    begin
      @(posedge core_clk);
    end
    q = prdata;
    slverr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Registers written at the access edge are visible to callers one edge later.
    @(posedge core_clk);
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [DATA_W-1:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rc(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string nm);
    logic [DATA_W-1:0] q;
    apb(1'b0, a, 8'h00, q);
    chk(nm, e, q[7:0]);
  endtask : rc

  task automatic settle;
    repeat (8) @(posedge core_clk);
  endtask : settle

  initial
  begin
    #50000;
    err_total++;
    end_of_test();
  end

  initial
  begin
    logic [DATA_W-1:0] q;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    // ****************************************
    // Reset values and unmapped access.
    // ****************************************
    rc(ADDR_DIR, 8'hFF, "direction");
    rc(ADDR_OPTION, 8'hFF, "option");
    rc(ADDR_MASK, 8'h00, "mask");
    chk("pullup_en", 8'h00, pullup_en);
    chk("pin_oe", 8'h00, pin_oe);
    rc(12'hFFC, 8'h00, "unmapped");
    chk("pslverr", 8'h01, {7'h00, slverr});
    chk("pready", 8'h01, {7'h00, pready});
    // ****************************************
    // Direction, latch and read-modify-write.
    // ****************************************
    ext_val <= 8'hC0;
    ext_en  <= 8'hF0;
    wr(ADDR_DIR, 8'hF0);
    wr(ADDR_PORT, 8'hA5);
    chk("pin_oe", 8'h0F, pin_oe);
    chk("pin_out", 8'hA5, pin_out);
    settle();
    rc(ADDR_PORT, 8'hC5, "port read");
    wr(ADDR_BITSET, 8'h02);
    chk("pin_out", 8'hC7, pin_out);
    rc(ADDR_BITSET, 8'hC7, "latch");
    settle();
    wr(ADDR_BITCLR, 8'h04);
    chk("pin_out", 8'hC3, pin_out);
    // ****************************************
    // Weak pull-ups.
    // ****************************************
    wr(ADDR_OPTION, 8'h7F);
    chk("pullup_en", 8'hF0, pullup_en);
    low_voltage_prog_enable <= 1'b1;
    @(posedge core_clk);
    chk("pullup_en", 8'hE0, pullup_en);
    low_voltage_prog_enable <= 1'b0;
    ext_en <= 8'h00;
    settle();
    rc(ADDR_PORT, 8'hF3, "pulled port");
    ext_en <= 8'hF0;
    wr(ADDR_OPTION, 8'hFF);
    chk("pullup_en", 8'h00, pullup_en);
    // ****************************************
    // Alternate functions.
    // ****************************************
    periph_sel <= 8'h10;
    periph_oe  <= 8'h10;
    periph_out <= 8'h10;
    @(posedge core_clk);
    chk("pin_oe", 8'h1F, pin_oe);
    chk("pin_out", 8'hD3, pin_out);
    periph_sel <= 8'h01;
    periph_out <= 8'h00;
    @(posedge core_clk);
    chk("pin_oe", 8'h0E, pin_oe);
    periph_sel <= 8'h00;
    periph_oe  <= 8'h00;
    // ****************************************
    // Change detection, flag, status and mask.
    // ****************************************
    ext_val <= 8'h50;
    settle();
    rc(ADDR_PORT, 8'h53, "port read");
    wr(ADDR_INTCTL, 8'h00);
    apb(1'b0, ADDR_STATUS, 8'h00, q);
    rc(ADDR_INTCTL, 8'h00, "flag idle");
    rc(ADDR_STATUS, 8'h00, "status idle");
    ext_val <= 8'h70;
    settle();
    chk("cpu_int_req", 8'h00, {7'h00, cpu_int_req});
    chk("irq", 8'h00, {7'h00, irq});
    rc(ADDR_INTCTL, 8'h01, "flag set");
    wr(ADDR_INTCTL, 8'h08);
    rc(ADDR_INTCTL, 8'h09, "flag held");
    chk("cpu_int_req", 8'h01, {7'h00, cpu_int_req});
    wr(ADDR_MASK, 8'h01);
    chk("irq", 8'h01, {7'h00, irq});
    rc(ADDR_PORT, 8'h73, "port read");
    rc(ADDR_STATUS, 8'h01, "status");
    rc(ADDR_STATUS, 8'h00, "status cleared");
    chk("irq", 8'h00, {7'h00, irq});
    wr(ADDR_INTCTL, 8'h08);
    rc(ADDR_INTCTL, 8'h08, "flag cleared");
    chk("cpu_int_req", 8'h00, {7'h00, cpu_int_req});
    // ****************************************
    // Exclusions and wake-up.
    // ****************************************
    wr(ADDR_DIR, 8'hD0);
    settle();
    rc(ADDR_INTCTL, 8'h08, "output excluded");
    low_voltage_prog_enable <= 1'b1;
    ext_val <= 8'h60;
    settle();
    rc(ADDR_INTCTL, 8'h08, "programming pin excluded");
    sleep_active <= 1'b1;
    low_voltage_prog_enable <= 1'b0;
    settle();
    chk("wake_req", 8'h01, {7'h00, wake_req});
    rc(ADDR_INTCTL, 8'h09, "flag set");
    rc(ADDR_PORT, 8'h43, "port read");
    rc(ADDR_STATUS, 8'h03, "status wake");
    wr(ADDR_INTCTL, 8'h00);
    sleep_active <= 1'b0;
    @(posedge core_clk);
    chk("wake_req", 8'h00, {7'h00, wake_req});
    end_of_test();
  end
endmodule : gpio_port_b_test
`default_nettype wire
